// >>> adcirq_pkg.sv
// adcirq_pkg: shared constants and flag layout for the adc interrupt flag logic
// assumes one master clock domain plus the serial link clock domain
`default_nettype none
package adcirq_pkg;
	// pending flags, one bit per event; 1 means an event is waiting
	typedef struct packed {
		logic por;
		logic crc;
		logic dr;
	} adcirq_flags_t;

	localparam int                     FLAG_W         = 3;
	localparam int                     TMR_W          = 24;
	localparam logic [FLAG_W-1:0]      PEND_RST       = 3'h4;
	localparam logic [7:0]             UNLOCK_KEY     = 8'ha5;
	localparam logic [TMR_W-1:0]       DR_LEAD_CYCLES = 24'h000010;
	localparam logic [TMR_W-1:0]       STARTUP_CYCLES = 24'h000100;
	localparam logic [TMR_W-1:0]       STP_CYCLES_DEF = 24'h000010;
	localparam int                     IRQ_MODE_W     = 2;
	localparam int                     IRQ_MODE_MASK  = 1;
endpackage
`default_nettype wire

// >>> adcirq_sync.sv
// adcirq_sync: two flip-flop level synchroniser
// assumes each bit is an independent level or a quasi-static word
`timescale 1ns/1ps
`default_nettype none
module adcirq_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule
`default_nettype wire

// >>> adcirq_timer.sv
// adcirq_timer: loadable down counter with busy level and terminal pulse
// assumes load is a single-cycle strobe on the same clock
`timescale 1ns/1ps
`default_nettype none
module adcirq_timer #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	output logic                  busy,
	output logic                  done
);
	logic [WIDTH-1:0] cnt_r;

	// count down to zero, reload on strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - WIDTH'(1);
		end
	end

	// busy while counting, done on the last counted cycle
	assign busy = (cnt_r != '0);
	assign done = (cnt_r == WIDTH'(1)) && !load;
endmodule
`default_nettype wire

// >>> adcirq_flags.sv
// adcirq_flags: event flags for status byte, interrupt register and interrupt pin
// assumes the serial command decoder gives link-clock strobes and the sequencer
// and checksum engine give master-clock strobes
`timescale 1ns/1ps
`default_nettype none
module adcirq_flags
	import adcirq_pkg::*;
#(
	parameter logic [TMR_W-1:0] START_PULSE_CYCLES = STP_CYCLES_DEF
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  link_clk,
	input  wire logic                  conv_done,
	input  wire logic                  conv_begin,
	input  wire logic [TMR_W-1:0]      conv_len,
	input  wire logic                  seq_start,
	input  wire logic                  scan_mode,
	input  wire logic                  crc_mismatch,
	input  wire logic                  lock_key_wr,
	input  wire logic [7:0]            lock_key,
	input  wire logic                  fast_restart,
	output logic                       crc_stop,
	output logic                       crc_restart,
	input  wire logic                  avdd_ok,
	input  wire logic                  dvdd_ok,
	input  wire logic                  cs_n,
	input  wire logic                  start_pulse_enable,
	input  wire logic [IRQ_MODE_W-1:0] irq_mode,
	input  wire logic                  bitstream_select,
	input  wire logic                  modulator_bitstream_output,
	input  wire logic                  sb_capture,
	input  wire logic                  sb_done,
	input  wire logic                  ir_capture,
	input  wire logic                  ir_done,
	input  wire logic                  adc_read_first,
	output adcirq_flags_t              sb_flags,
	output adcirq_flags_t              ir_flags,
	output logic                       irq_n
);
	adcirq_flags_t pend_sb_r;
	adcirq_flags_t pend_sb_nxt;
	adcirq_flags_t pend_ir_r;
	adcirq_flags_t pend_ir_nxt;
	adcirq_flags_t events;
	adcirq_flags_t sb_mask_s;
	adcirq_flags_t ir_mask_s;
	adcirq_flags_t pend_sb_l;
	adcirq_flags_t pend_ir_l;
	adcirq_flags_t sb_cap_r;
	adcirq_flags_t ir_cap_r;
	logic          sb_tgl_r;
	logic          ir_tgl_r;
	logic          adc_tgl_r;
	logic [2:0]    tgl_s;
	logic [2:0]    tgl_prev_r;
	logic          sb_clr;
	logic          ir_clr;
	logic          adc_clr;
	logic          avdd_s;
	logic          dvdd_s;
	logic          cs_s;
	logic          cs_prev_r;
	logic          supply_low;
	logic          cs_fall;
	logic          dr_pin_r;
	logic          crc_pin_r;
	logic          por_pin_r;
	logic          unlock;
	logic          crc_clr;
	logic          early_clr;
	logic          startup_done;
	logic          stp_go;
	logic          stp_busy;
	logic          irq_n_r;
	logic          irq_n_nxt;
	logic [TMR_W-1:0] early_val;

	// pins from outside the master clock domain
	adcirq_sync #(.WIDTH(3)) u_pin_sync (
		.clk (clk),
		.d   ({avdd_ok, dvdd_ok, cs_n}),
		.q   ({avdd_s, dvdd_s, cs_s})
	);

	// link strobes and captured masks into the master clock domain
	adcirq_sync #(.WIDTH(3 + 2 * FLAG_W)) u_link_to_core (
		.clk (clk),
		.d   ({sb_tgl_r, ir_tgl_r, adc_tgl_r, sb_cap_r, ir_cap_r}),
		.q   ({tgl_s, sb_mask_s, ir_mask_s})
	);

	// pending flags into the link domain
	adcirq_sync #(.WIDTH(2 * FLAG_W)) u_core_to_link (
		.clk (link_clk),
		.d   ({pend_sb_r, pend_ir_r}),
		.q   ({pend_sb_l, pend_ir_l})
	);

	// link side capture of the status byte flags
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			sb_cap_r <= '0;
			sb_flags <= '1;
		end else if (sb_capture) begin
			sb_cap_r <= pend_sb_l;
			sb_flags <= ~pend_sb_l;
		end
	end

	// link side capture of the interrupt register flags
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ir_cap_r <= '0;
			ir_flags <= '1;
		end else if (ir_capture) begin
			ir_cap_r <= pend_ir_l;
			ir_flags <= ~pend_ir_l;
		end
	end

	// link side end-of-transfer events as toggles
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			sb_tgl_r  <= 1'b0;
			ir_tgl_r  <= 1'b0;
			adc_tgl_r <= 1'b0;
		end else begin
			sb_tgl_r  <= sb_tgl_r ^ sb_done;
			ir_tgl_r  <= ir_tgl_r ^ ir_done;
			adc_tgl_r <= adc_tgl_r ^ adc_read_first;
		end
	end

	// toggle edge detection in the master domain
	always_ff @(posedge clk) begin
		if (rst) begin
			tgl_prev_r <= '0;
		end else begin
			tgl_prev_r <= tgl_s;
		end
	end
	assign sb_clr  = tgl_s[2] ^ tgl_prev_r[2];
	assign ir_clr  = tgl_s[1] ^ tgl_prev_r[1];
	assign adc_clr = tgl_s[0] ^ tgl_prev_r[0];

	// supply level and select edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_prev_r <= 1'b1;
		end else begin
			cs_prev_r <= cs_s;
		end
	end
	assign supply_low = !avdd_s || !dvdd_s;
	assign cs_fall    = cs_prev_r && !cs_s;

	// events that feed status byte and register; start pulse has no entry
	always_comb begin
		events     = '0;
		events.dr  = conv_done;
		events.crc = crc_mismatch;
		events.por = supply_low;
	end

	// pending next values: a new event wins over the clear
	always_comb begin
		pend_sb_nxt = (pend_sb_r & ~(sb_clr ? sb_mask_s : '0)) | events;
		pend_ir_nxt = (pend_ir_r & ~(ir_clr ? ir_mask_s : '0)) | events;
	end

	// pending flags, power-on pending after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_sb_r <= PEND_RST;
			pend_ir_r <= PEND_RST;
		end else begin
			pend_sb_r <= pend_sb_nxt;
			pend_ir_r <= pend_ir_nxt;
		end
	end

	// early data ready clear before the conversion ends
	assign early_val = (conv_len > DR_LEAD_CYCLES) ? (conv_len - DR_LEAD_CYCLES) : TMR_W'(1);
	adcirq_timer #(.WIDTH(TMR_W)) u_early (
		.clk      (clk),
		.rst      (rst),
		.load     (conv_begin),
		.load_val (early_val),
		.busy     (),
		.done     (early_clr)
	);

	// data ready pin source, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			dr_pin_r <= 1'b0;
		end else if (conv_done) begin
			dr_pin_r <= 1'b1;
		end else if (adc_clr || early_clr) begin
			dr_pin_r <= 1'b0;
		end
	end

	// startup delay before the first sample in mux mode
	adcirq_timer #(.WIDTH(TMR_W)) u_startup (
		.clk      (clk),
		.rst      (rst),
		.load     (seq_start && !scan_mode),
		.load_val (STARTUP_CYCLES),
		.busy     (),
		.done     (startup_done)
	);
	assign stp_go = scan_mode ? seq_start : startup_done;

	// start pulse width, released without host action
	adcirq_timer #(.WIDTH(TMR_W)) u_stp (
		.clk      (clk),
		.rst      (rst),
		.load     (stp_go),
		.load_val (START_PULSE_CYCLES),
		.busy     (stp_busy),
		.done     ()
	);

	// checksum error clear sources
	assign unlock  = lock_key_wr && (lock_key == UNLOCK_KEY);
	assign crc_clr = unlock || fast_restart;

	// checksum error pin source, held until cleared
	always_ff @(posedge clk) begin
		if (rst) begin
			crc_pin_r <= 1'b0;
		end else if (crc_mismatch) begin
			crc_pin_r <= 1'b1;
		end else if (crc_clr) begin
			crc_pin_r <= 1'b0;
		end
	end

	// checksum engine control strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			crc_stop    <= 1'b0;
			crc_restart <= 1'b0;
		end else begin
			crc_stop    <= unlock;
			crc_restart <= fast_restart;
		end
	end

	// power-on pin source, active from power-up
	always_ff @(posedge clk) begin
		if (rst) begin
			por_pin_r <= 1'b1;
		end else if (supply_low) begin
			por_pin_r <= 1'b1;
		end else if (cs_fall) begin
			por_pin_r <= 1'b0;
		end
	end

	// pin priority: power-on, checksum error, bitstream, then events
	always_comb begin
		if (por_pin_r) begin
			irq_n_nxt = 1'b0;
		end else if (crc_pin_r) begin
			irq_n_nxt = 1'b0;
		end else if (bitstream_select) begin
			irq_n_nxt = modulator_bitstream_output;
		end else if (irq_mode[IRQ_MODE_MASK]) begin
			irq_n_nxt = 1'b1;
		end else begin
			irq_n_nxt = !(dr_pin_r || (stp_busy && start_pulse_enable));
		end
	end

	// registered pin drive, low during reset
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_n_r <= 1'b0;
		end else begin
			irq_n_r <= irq_n_nxt;
		end
	end
	assign irq_n = irq_n_r;

	// checks on pin and flag behaviour
	a_por_forces_low: assert property (@(posedge clk) disable iff (rst)
		por_pin_r |=> !irq_n_r) else $error("power-on did not force pin low");
	a_supply_drop: assert property (@(posedge clk) disable iff (rst)
		supply_low |=> por_pin_r ##1 !irq_n_r) else $error("supply drop not shown on pin");
	a_por_release: assert property (@(posedge clk) disable iff (rst)
		(por_pin_r && !supply_low && !cs_fall) |=> por_pin_r)
		else $error("power-on pin cleared without select edge");
	a_crc_held: assert property (@(posedge clk) disable iff (rst)
		(crc_pin_r && !crc_clr) |=> crc_pin_r) else $error("checksum error released early");
	a_crc_clear: assert property (@(posedge clk) disable iff (rst)
		(crc_clr && !crc_mismatch) |=> !crc_pin_r && (crc_stop == $past(unlock)))
		else $error("checksum clear failed");
	a_crc_priority: assert property (@(posedge clk) disable iff (rst)
		(crc_pin_r && !por_pin_r) |=> !irq_n_r) else $error("checksum error lost priority");
	a_dr_pin_fall: assert property (@(posedge clk) disable iff (rst)
		(conv_done && !por_pin_r && !crc_pin_r && !bitstream_select && !irq_mode[1])
		|=> dr_pin_r ##1 !irq_n_r) else $error("data ready did not pull pin low");
	a_mode_masks: assert property (@(posedge clk) disable iff (rst)
		(irq_mode[1] && !por_pin_r && !crc_pin_r && !bitstream_select) |=> irq_n_r)
		else $error("masked event reached the pin");
	a_dr_pending: assert property (@(posedge clk) disable iff (rst)
		conv_done |=> pend_sb_r.dr && pend_ir_r.dr) else $error("data ready not pending");
	a_stp_gated: assert property (@(posedge clk) disable iff (rst)
		(!start_pulse_enable && !dr_pin_r && !por_pin_r && !crc_pin_r && !bitstream_select)
		|=> irq_n_r) else $error("disabled start pulse reached pin");
	a_early_clear: assert property (@(posedge clk) disable iff (rst)
		(early_clr && !conv_done) |=> !dr_pin_r) else $error("early clear missed");
endmodule
`default_nettype wire

// >>> adcirq_host.sv
// adcirq_host: behavioural serial host issuing framed commands
// assumes the flag logic samples its link strobes on the rising link clock
`timescale 1ns/1ps
`default_nettype none
module adcirq_host (
	output logic link_clk,
	output logic cs_n,
	output logic sb_capture,
	output logic sb_done,
	output logic ir_capture,
	output logic ir_done,
	output logic adc_read_first
);
	// idle: link clock stands still low, select high
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		{sb_capture, sb_done, ir_capture, ir_done, adc_read_first} = 5'h00;
	end

	// one frame; strobes move while the link clock is low
	task frame(input logic rd, input logic res);
		cs_n = 1'b0;
		#200;
		for (int c = 0; c < 16; c++) begin
			sb_capture = (c == 3);
			sb_done = (c == 6);
			ir_capture = rd && (c == 7);
			ir_done = rd && (c == 10);
			adc_read_first = res && (c == 11);
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		#100 cs_n = 1'b1;
		#300;
	endtask
endmodule
`default_nettype wire

// >>> adcirq_flags_tb.sv
// adcirq_flags_tb: directed checks of the flag byte, register and pin paths
// assumes adcirq_host drives the link side and supplies start good
`timescale 1ns/1ps
`default_nettype none
module adcirq_flags_tb
	import adcirq_pkg::*;
;
	logic                  clk = 1'b0;
	logic                  rst = 1'b0;
	logic                  conv_done = 1'b0, conv_begin = 1'b0, seq_start = 1'b0;
	logic                  scan_mode = 1'b0, crc_mismatch = 1'b0, lock_key_wr = 1'b0;
	logic                  fast_restart = 1'b0, avdd_ok = 1'b1, dvdd_ok = 1'b1;
	logic                  start_pulse_enable = 1'b1, bitstream_select = 1'b0;
	logic                  modulator_bitstream_output = 1'b0;
	logic [7:0]            lock_key = 8'h00;
	logic [TMR_W-1:0]      conv_len = 24'h000028;
	logic [IRQ_MODE_W-1:0] irq_mode = 2'h0;
	wire logic             link_clk, cs_n, sb_capture, sb_done, ir_capture, ir_done;
	wire logic             adc_read_first, crc_stop, crc_restart, irq_n;
	adcirq_flags_t         sb_flags, ir_flags;
	int                    miscompares = 0, checks = 0, n;

	// master clock, 100 ns period
	always #50 clk = ~clk;

	adcirq_host u_host (
		.link_clk(link_clk), .cs_n(cs_n), .sb_capture(sb_capture), .sb_done(sb_done),
		.ir_capture(ir_capture), .ir_done(ir_done), .adc_read_first(adc_read_first)
	);

	adcirq_flags #(.START_PULSE_CYCLES(24'h000002)) u_adcirq_flags (
		.clk(clk), .rst(rst), .link_clk(link_clk), .conv_done(conv_done),
		.conv_begin(conv_begin), .conv_len(conv_len), .seq_start(seq_start),
		.scan_mode(scan_mode), .crc_mismatch(crc_mismatch), .lock_key_wr(lock_key_wr),
		.lock_key(lock_key), .fast_restart(fast_restart), .crc_stop(crc_stop),
		.crc_restart(crc_restart), .avdd_ok(avdd_ok), .dvdd_ok(dvdd_ok), .cs_n(cs_n),
		.start_pulse_enable(start_pulse_enable), .irq_mode(irq_mode),
		.bitstream_select(bitstream_select),
		.modulator_bitstream_output(modulator_bitstream_output),
		.sb_capture(sb_capture), .sb_done(sb_done), .ir_capture(ir_capture),
		.ir_done(ir_done), .adc_read_first(adc_read_first), .sb_flags(sb_flags),
		.ir_flags(ir_flags), .irq_n(irq_n)
	);

	// step k edges, land 5 ns after the last one
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task pin(input logic e, input string m);
		chk({7'h0, irq_n}, {7'h0, e}, m);
	endtask

	task print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one master clock cycle strobe
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask

	// bounded wait for the pin level; n holds the edges taken
	task wait_pin(input logic lvl, input int max);
		n = 0;
		while (irq_n !== lvl) begin
			cyc(1);
			n++;
			if (n > max) begin
				chk(8'h0, 8'h1, "pin wait timed out");
				print_verdict;
			end
		end
	endtask

	// a strobe output must be high for exactly one of three edges
	task strobes(input logic rs);
		n = 0;
		repeat (3) begin
			if ((rs ? crc_restart : crc_stop) === 1'b1) n++;
			cyc(1);
		end
		chk(n[7:0], 8'h1, "one cycle strobe");
	endtask

	// frame with status byte and register read, then both flag words
	task frm(input logic res, input logic [2:0] sb, input logic [2:0] ir);
		u_host.frame(1'b1, res);
		cyc(8);
		chk({5'h0, sb_flags}, {5'h0, sb}, "status byte flags");
		chk({5'h0, ir_flags}, {5'h0, ir}, "register flags");
	endtask

	initial begin
		// reset and power-on reporting; reset rises as an edge so the link flops see it
		cyc(0);
		rst = 1'b1;
		cyc(1);
		pin(1'b0, "pin in reset");
		chk({5'h0, sb_flags}, 8'h07, "status in reset");
		cyc(4);
		rst = 1'b0;
		cyc(3);
		pin(1'b0, "pin after release");
		frm(1'b0, 3'b011, 3'b011);
		pin(1'b1, "pin freed by select");
		frm(1'b0, 3'b111, 3'b111);
		$display("test reset done");
		// data ready on all paths, cleared by result read or countdown
		pulse(conv_done);
		cyc(2);
		pin(1'b0, "dr pin low");
		frm(1'b1, 3'b110, 3'b110);
		pin(1'b1, "dr cleared by read");
		frm(1'b0, 3'b111, 3'b111);
		pulse(conv_done);
		pulse(conv_begin);
		cyc(20);
		pin(1'b0, "dr pin held");
		cyc(8);
		pin(1'b1, "dr early clear");
		frm(1'b0, 3'b110, 3'b110);
		irq_mode = 2'h2;
		pulse(conv_done);
		cyc(4);
		pin(1'b1, "dr masked by mode");
		frm(1'b1, 3'b110, 3'b110);
		irq_mode = 2'h0;
		$display("test data ready done");
		// start pulse: delayed, immediate in scan, then disabled
		for (int i = 0; i < 3; i++) begin
			scan_mode = (i == 1);
			start_pulse_enable = (i != 2);
			cyc(1);
			pulse(seq_start);
			if (i == 2) begin
				n = 0;
				repeat (300) begin
					cyc(1);
					if (irq_n !== 1'b1) n++;
				end
				chk({7'h0, n != 0}, 8'h0, "start pulse disabled");
			end else begin
				wait_pin(1'b0, 300);
				chk({7'h0, (i == 1) ? (n < 5) : (n >= 256 && n <= 262)}, 8'h1, "delay");
				wait_pin(1'b1, 10);
				chk({7'h0, n <= 4}, 8'h1, "start pulse width");
			end
			frm(1'b0, 3'b111, 3'b111);
		end
		$display("test start pulse done");
		// checksum error outranks bitstream and mode mask
		irq_mode = 2'h2;
		bitstream_select = 1'b1;
		modulator_bitstream_output = 1'b1;
		cyc(4);
		pin(1'b1, "bitstream high");
		pulse(crc_mismatch);
		cyc(2);
		pin(1'b0, "crc pin low");
		pulse(lock_key_wr);
		cyc(3);
		pin(1'b0, "crc held on wrong key");
		frm(1'b0, 3'b101, 3'b101);
		lock_key = UNLOCK_KEY;
		pulse(lock_key_wr);
		strobes(1'b0);
		pin(1'b1, "crc cleared by unlock");
		modulator_bitstream_output = 1'b0;
		cyc(3);
		pin(1'b0, "bitstream low");
		modulator_bitstream_output = 1'b1;
		frm(1'b0, 3'b111, 3'b111);
		pulse(crc_mismatch);
		cyc(1);
		pulse(crc_mismatch);
		pulse(fast_restart);
		strobes(1'b1);
		cyc(2);
		pin(1'b1, "crc cleared by restart");
		frm(1'b0, 3'b101, 3'b101);
		$display("test checksum done");
		// each supply drop forces the pin low until a select with both good
		for (int i = 0; i < 2; i++) begin
			avdd_ok = (i != 0);
			dvdd_ok = (i == 0);
			cyc(6);
			pin(1'b0, "supply low pin");
			u_host.frame(1'b0, 1'b0);
			cyc(6);
			pin(1'b0, "select with supply low");
			avdd_ok = 1'b1;
			dvdd_ok = 1'b1;
			cyc(6);
			pin(1'b0, "held until select");
			frm(1'b0, 3'b011, 3'b011);
			pin(1'b1, "select clears pin");
		end
		$display("test power-on done");
		print_verdict;
	end
endmodule
`default_nettype wire
